// ---- rdwc_top.sv ----
// rail turn-on delay and supply warning configuration registers
// assumes a same-clock register port and an analog strap sensor on pins
`timescale 1ns/1ps
`default_nettype none
module rdwc_top
  import rdwc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire rdwc_pkg::rdwc_req_t req,
  output logic [7:0] rdata,
  output logic ack,
  input wire logic strap_sense_high,
  input wire logic strap_sense_low,
  output rdwc_pkg::rdwc_delays_t delays,
  output logic [5:0] buck_four_steps_left,
  output logic [3:0] supply_warning_level_code,
  output logic [3:0] supply_monitor_level_code,
  output logic [11:0] supply_warning_mv,
  output logic [11:0] supply_monitor_mv,
  output logic config_loaded
);
  import rdwc_pkg::*;

  logic [1:0] sync_high;
  logic [1:0] sync_low;
  rdwc_strap_t strap;
  logic loaded;
  logic [7:0] strap_delay_cfg0;
  logic [7:0] strap_delay_cfg1;
  logic [7:0] supply_warning_thresholds;
  wire logic hit0;
  wire logic hit1;
  wire logic hit2;
  wire logic [7:0] dflt0;
  wire logic [7:0] dflt1;
  wire rdwc_strap_t strap_now;
  logic applied;
  logic started;
  logic [7:0] cfg0_eff;
  logic [7:0] cfg1_eff;

  // two-stage synchronisers on the strap sense pins
  always_ff @(posedge clk)
  begin
    sync_high <= {sync_high[0], strap_sense_high};
    sync_low <= {sync_low[0], strap_sense_low};
  end

  // decode the settled strap level
  assign strap_now = sync_high[1] ? RDWC_STRAP_HIGH :
    (sync_low[1] ? RDWC_STRAP_LOW : RDWC_STRAP_FLOAT);
  assign dflt0 = (strap == RDWC_STRAP_HIGH) ? RDWC_D0_HIGH :
    ((strap == RDWC_STRAP_LOW) ? RDWC_D0_LOW : RDWC_D0_FLOAT);
  assign dflt1 = (strap == RDWC_STRAP_HIGH) ? RDWC_D1_HIGH :
    ((strap == RDWC_STRAP_LOW) ? RDWC_D1_LOW : RDWC_D1_FLOAT);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap <= RDWC_STRAP_FLOAT;
      loaded <= 1'b0;
    end
    else if (!loaded)
    begin
      strap <= strap_now;
      loaded <= 1'b1;
    end
  end

  assign hit0 = req.addr == RDWC_OFS_DELAY0;
  assign hit1 = req.addr == RDWC_OFS_DELAY1;
  assign hit2 = req.addr == RDWC_OFS_WARN;
  // no request is taken while reset is held
  assign ack = req_valid && loaded && !reset;

  // register writes; delay defaults load the cycle after capture
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap_delay_cfg0 <= 8'h00;
      strap_delay_cfg1 <= 8'h00;
      supply_warning_thresholds <= RDWC_WARN_RESET;
    end
    else if (!applied)
    begin
      // strap defaults land in the registers themselves
      strap_delay_cfg0 <= dflt0;
      strap_delay_cfg1 <= dflt1;
    end
    else if (ack && req.wr)
    begin
      if (hit0)
        strap_delay_cfg0 <= req.wdata;
      if (hit1)
        strap_delay_cfg1 <= req.wdata;
      if (hit2)
        supply_warning_thresholds <= req.wdata;
    end
  end

  // defaults applied once, in the cycle after the strap is captured
  always_ff @(posedge clk)
  begin
    if (reset)
      applied <= 1'b0;
    else if (loaded)
      applied <= 1'b1;
  end
  assign cfg0_eff = applied ? strap_delay_cfg0 : dflt0;
  assign cfg1_eff = applied ? strap_delay_cfg1 : dflt1;
  assign config_loaded = applied;

  // read data, unmapped reads as zero
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata <= 8'h00;
    else if (ack && !req.wr)
      rdata <= hit0 ? cfg0_eff : (hit1 ? cfg1_eff :
        (hit2 ? supply_warning_thresholds : 8'h00));
  end

  assign delays.buck_four_turnon_delay = cfg0_eff[7:RDWC_BUCK4_LSB];
  assign delays.linreg_a_delay = {cfg0_eff[1:0], cfg1_eff[7:RDWC_LINA_LOW_LSB]};
  assign delays.linreg_b_turnon_delay = cfg1_eff[5:0];

  // quarter ms step timebase and buck four countdown demo
  localparam logic [14:0] STEP_LAST = 15'(RDWC_STEP_CYCLES - 1);
  logic [14:0] tick_cnt;
  wire logic step_tick;
  assign step_tick = tick_cnt == STEP_LAST;
  always_ff @(posedge clk)
  begin
    if (reset || !applied)
    begin
      tick_cnt <= 15'h0000;
      buck_four_steps_left <= 6'h00;
    end
    else
    begin
      tick_cnt <= step_tick ? 15'h0000 : tick_cnt + 15'h0001;
      if (buck_four_steps_left == 6'h00 && tick_cnt == 15'h0000 && !started)
        buck_four_steps_left <= delays.buck_four_turnon_delay;
      else if (step_tick && buck_four_steps_left != 6'h00)
        buck_four_steps_left <= buck_four_steps_left - 6'h01;
    end
  end
  always_ff @(posedge clk)
  begin
    if (reset || !applied)
      started <= 1'b0;
    else
      started <= 1'b1;
  end

  assign supply_warning_level_code = supply_warning_thresholds[7:4];
  assign supply_warning_mv = 12'(RDWC_WARN_OFFSET_MV) +
    12'(supply_warning_level_code) * 12'(RDWC_LEVEL_STEP_MV);
  assign supply_monitor_level_code = supply_warning_thresholds[3:0];
  assign supply_monitor_mv = 12'(RDWC_MON_OFFSET_MV) +
    12'(supply_monitor_level_code) * 12'(RDWC_LEVEL_STEP_MV);

  property p_strap_hold;
    @(posedge clk) disable iff (reset) loaded && $past(loaded) |-> $stable(strap);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
  property p_d0_high;
    @(posedge clk) disable iff (reset)
      loaded && !applied && strap == RDWC_STRAP_HIGH |-> cfg0_eff == RDWC_D0_HIGH;
  endproperty
  a_d0_high: assert property (p_d0_high) else $error("delay0 default wrong");
  property p_d1_low;
    @(posedge clk) disable iff (reset)
      loaded && !applied && strap == RDWC_STRAP_LOW |-> cfg1_eff == RDWC_D1_LOW;
  endproperty
  a_d1_low: assert property (p_d1_low) else $error("delay1 default wrong");
  property p_buck4;
    @(posedge clk) disable iff (reset)
      applied && ack && req.wr && hit0 |=> delays.buck_four_turnon_delay == $past(req.wdata[7:2]);
  endproperty
  a_buck4: assert property (p_buck4) else $error("buck four field wrong");
  property p_lina;
    @(posedge clk) disable iff (reset)
      applied && ack && req.wr && hit0 |=> delays.linreg_a_delay[3:2] == $past(req.wdata[1:0]);
  endproperty
  a_lina: assert property (p_lina) else $error("linreg a code wrong");
  property p_linb;
    @(posedge clk) disable iff (reset)
      applied && ack && req.wr && hit1 |=> delays.linreg_b_turnon_delay == $past(req.wdata[5:0]);
  endproperty
  a_linb: assert property (p_linb) else $error("linreg b field wrong");
  property p_warn;
    @(posedge clk) disable iff (reset)
      supply_warning_mv >= 12'd2775 && supply_warning_mv <= 12'd3150;
  endproperty
  a_warn: assert property (p_warn) else $error("warning level out of range");
  property p_mon;
    @(posedge clk) disable iff (reset)
      supply_monitor_mv == 12'd2725 + 12'd25 * 12'(supply_monitor_level_code);
  endproperty
  a_mon: assert property (p_mon) else $error("monitor level wrong");
endmodule
`default_nettype wire

// ---- rdwc_pkg.sv ----
// package for the rail delay and warning configuration block
// assumes an 8-bit register port with byte offsets as printed
package rdwc_pkg;
  // register offsets
  localparam logic [7:0] RDWC_OFS_DELAY0 = 8'h0d;
  localparam logic [7:0] RDWC_OFS_DELAY1 = 8'h0e;
  localparam logic [7:0] RDWC_OFS_WARN = 8'h0f;
  // strap reset values per pin state
  localparam logic [7:0] RDWC_D0_HIGH = 8'h25;
  localparam logic [7:0] RDWC_D0_FLOAT = 8'h00;
  localparam logic [7:0] RDWC_D0_LOW = 8'h15;
  localparam logic [7:0] RDWC_D1_HIGH = 8'h8e;
  localparam logic [7:0] RDWC_D1_FLOAT = 8'h08;
  localparam logic [7:0] RDWC_D1_LOW = 8'hc8;
  localparam logic [7:0] RDWC_WARN_RESET = 8'h00;
  // field positions
  localparam int RDWC_BUCK4_LSB = 2;
  localparam int RDWC_LINA_LOW_LSB = 6;
  // timing: one delay step in ns and in cycles at 100 MHz
  localparam int RDWC_CLK_PERIOD_NS = 10;
  localparam int RDWC_STEP_NS = 250000;
  localparam int RDWC_STEP_CYCLES = RDWC_STEP_NS / RDWC_CLK_PERIOD_NS;
  // threshold scale in mV
  localparam int RDWC_WARN_OFFSET_MV = 2775;
  localparam int RDWC_MON_OFFSET_MV = 2725;
  localparam int RDWC_LEVEL_STEP_MV = 25;
  // strap levels
  typedef enum logic [1:0] {RDWC_STRAP_FLOAT = 2'b00, RDWC_STRAP_HIGH = 2'b01,
    RDWC_STRAP_LOW = 2'b10} rdwc_strap_t;
  // register bus request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rdwc_req_t;
  // delay codes handed to the sequencer
  typedef struct packed {
    logic [5:0] buck_four_turnon_delay;
    logic [3:0] linreg_a_delay;
    logic [5:0] linreg_b_turnon_delay;
  } rdwc_delays_t;
endpackage

// ---- rdwc_tb_top.sv ----
// self-checking bench for the rail delay and supply warning registers
// assumes rdwc_pkg and rdwc_top are compiled first; inputs move on falling edges
`timescale 1ns/1ps
`default_nettype none
module rdwc_tb_top;
  import rdwc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} rdwc_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  rdwc_req_t req = '0;
  logic sh = 1'b0;
  logic sl = 1'b0;
  logic [7:0] rdata, rd, d0, d1, w;
  logic ack, config_loaded;
  logic [5:0] steps;
  rdwc_delays_t delays;
  logic [3:0] warn_code, mon_code;
  logic [11:0] warn_mv, mon_mv;
  int error_cnt = 0;
  int cmp_count = 0;
  // strap rows: high, low, delay0 default, delay1 default
  logic [17:0] straps [3] = '{{2'b10, 8'h25, 8'h8e}, {2'b00, 8'h00, 8'h08},
    {2'b01, 8'h15, 8'hc8}};
  // plain rows: offset, write data, expected read back
  rdwc_row_t rows [7] = '{'{8'h0d, 8'hfc, 8'hfc}, '{8'h0e, 8'h3f, 8'h3f},
    '{8'h0f, 8'hf0, 8'hf0}, '{8'h0f, 8'h0f, 8'h0f}, '{8'h0e, 8'hc0, 8'hc0},
    '{8'h0d, 8'h03, 8'h03}, '{8'h20, 8'h55, 8'h00}};

  // free running clock
  always #5 clk = ~clk;

  rdwc_top dut_u (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req),
    .rdata(rdata), .ack(ack), .strap_sense_high(sh), .strap_sense_low(sl),
    .delays(delays), .buck_four_steps_left(steps), .supply_warning_level_code(warn_code),
    .supply_monitor_level_code(mon_code), .supply_warning_mv(warn_mv),
    .supply_monitor_mv(mon_mv), .config_loaded(config_loaded));

  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // one register access, held until acked, read data taken after the edge
  task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int i;
    begin
      @(negedge clk);
      req_valid = 1'b1;
      req = '{wr: wr, addr: a, wdata: d};
      #1;
      i = 0;
      while (ack !== 1'b1 && i < 20)
      begin
        @(negedge clk);
        #1;
        i++;
      end
      if (ack !== 1'b1)
      begin
        error_cnt++;
        final_report();
      end
      @(negedge clk);
      req_valid = 1'b0;
      rd = rdata;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    begin
      reg_acc(1'b0, a, 8'h00);
      chk({8'h00, rd}, {8'h00, e});
    end
  endtask

  // outputs against the shadow copies of the three registers
  task automatic check_outs;
    begin
      chk(delays, {d0[7:2], d0[1:0], d1[7:6], d1[5:0]});
      chk({8'h00, warn_code, mon_code}, {8'h00, w});
      chk({4'h0, warn_mv}, 16'(RDWC_WARN_OFFSET_MV + RDWC_LEVEL_STEP_MV * w[7:4]));
      chk({4'h0, mon_mv}, 16'(RDWC_MON_OFFSET_MV + RDWC_LEVEL_STEP_MV * w[3:0]));
    end
  endtask

  // reset with a write pending that must be refused
  task automatic do_reset(input logic hi, input logic lo);
    int i;
    begin
      @(negedge clk);
      reset = 1'b1;
      sh = hi;
      sl = lo;
      req_valid = 1'b1;
      req = '{wr: 1'b1, addr: RDWC_OFS_WARN, wdata: 8'hff};
      repeat (6) @(negedge clk);
      chk({15'h0000, ack}, 16'h0000);
      req_valid = 1'b0;
      reset = 1'b0;
      i = 0;
      while (config_loaded !== 1'b1 && i < 20)
      begin
        @(negedge clk);
        i++;
      end
      if (config_loaded !== 1'b1)
      begin
        error_cnt++;
        final_report();
      end
      repeat (2) @(negedge clk);
    end
  endtask

  initial
  begin
    // defaults per strap state, then pins moved without reset
    for (int s = 0; s < 3; s++)
    begin
      do_reset(straps[s][17], straps[s][16]);
      d0 = straps[s][15:8];
      d1 = straps[s][7:0];
      w = 8'h00;
      rd_chk(RDWC_OFS_DELAY0, d0);
      rd_chk(RDWC_OFS_DELAY1, d1);
      rd_chk(RDWC_OFS_WARN, w);
      check_outs();
      chk({10'h000, steps}, {10'h000, d0[7:2]});
      // one full quarter ms step later the countdown is one lower
      if (s == 0)
      begin
        repeat (RDWC_STEP_CYCLES) @(negedge clk);
        chk({10'h000, steps}, {10'h000, d0[7:2] - 6'h01});
      end
      {sh, sl} = straps[s][17] ? 2'b01 : 2'b10;
      repeat (4) @(negedge clk);
      rd_chk(RDWC_OFS_DELAY0, d0);
      rd_chk(RDWC_OFS_DELAY1, d1);
    end
    // field boundaries and an unmapped offset
    for (int k = 0; k < 7; k++)
    begin
      reg_acc(1'b1, rows[k].a, rows[k].d);
      if (rows[k].a == RDWC_OFS_DELAY0)
        d0 = rows[k].e;
      if (rows[k].a == RDWC_OFS_DELAY1)
        d1 = rows[k].e;
      if (rows[k].a == RDWC_OFS_WARN)
        w = rows[k].e;
      rd_chk(rows[k].a, rows[k].e);
      check_outs();
    end
    final_report();
  end
endmodule
`default_nettype wire
